// ### rtl/cevc_top.sv
// Purpose: core event controller, ranks events and hands them to the core
// Assumes: event pins are asynchronous, exception and return from core
// Notes: unmask bits and global enable come from the core's own registers
`timescale 1ns/100ps
`default_nettype none
module cevc_top (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic EMU_REQ,
  input wire logic RESET_REQ,
  input wire logic NMI_PIN,
  input wire logic WDOG_NMI,
  input wire logic HWERR_REQ,
  input wire logic TIMER_REQ,
  input wire logic [8:0] GEN_IRQ,
  input wire logic EXC_REQ,
  input wire logic GLOBAL_EN,
  input wire logic [15:0] EVENT_UNMASK,
  input wire logic [31:0] CORE_PC,
  input wire logic RET_REQ,
  input wire logic [3:0] RET_LEVEL,
  output logic TAKE_PULSE,
  output logic [3:0] TAKE_LEVEL,
  output logic [15:0] EVENT_ACTIVE,
  output logic [15:0] EVENT_LATCH,
  output logic EMU_MODE,
  output logic CORE_RESET,
  output logic COMMIT_BLOCK,
  output logic RET_VALID,
  output logic [31:0] RET_ADDR
);
  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and edge detect
  logic [cevc_pkg::PIN_W-1:0] pin_raw;
  logic [cevc_pkg::PIN_W-1:0] s1_q;
  logic [cevc_pkg::PIN_W-1:0] s2_q;
  logic [cevc_pkg::PIN_W-1:0] s3_q;
  logic [cevc_pkg::PIN_W-1:0] pin_edge;
  cevc_pkg::cevc_vec_t edge_evt;

  assign pin_raw = {GEN_IRQ, TIMER_REQ, HWERR_REQ, WDOG_NMI, NMI_PIN,
    RESET_REQ, EMU_REQ};

  genvar gi;
  generate
    for (gi = 0; gi < cevc_pkg::PIN_W; gi++) begin : g_sync
      always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
          s1_q[gi] <= 1'b0;
          s2_q[gi] <= 1'b0;
          s3_q[gi] <= 1'b0;
        end else begin
          s1_q[gi] <= pin_raw[gi];
          s2_q[gi] <= s1_q[gi];
          s3_q[gi] <= s2_q[gi];
        end
      end
      assign pin_edge[gi] = s2_q[gi] & ~s3_q[gi];
    end
  endgenerate

  // event vector in priority order
  always_comb begin
    edge_evt = '0;
    edge_evt[cevc_pkg::LVL_EMU] = pin_edge[cevc_pkg::PIN_EMU];
    edge_evt[cevc_pkg::LVL_RST] = pin_edge[cevc_pkg::PIN_RST];
    edge_evt[cevc_pkg::LVL_NMI] = pin_edge[cevc_pkg::PIN_NMI] |
      pin_edge[cevc_pkg::PIN_WDOG];
    edge_evt[cevc_pkg::LVL_EXC] = EXC_REQ;
    edge_evt[cevc_pkg::LVL_HWE] = pin_edge[cevc_pkg::PIN_HWE];
    edge_evt[cevc_pkg::LVL_TMR] = pin_edge[cevc_pkg::PIN_TMR];
    edge_evt[15:7] = pin_edge[cevc_pkg::PIN_W-1:cevc_pkg::PIN_GP0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // ranking
  function automatic logic [4:0] cevc_first(input logic [15:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 15; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction

  cevc_pkg::cevc_vec_t latch_q;
  cevc_pkg::cevc_vec_t latch_d;
  cevc_pkg::cevc_vec_t active_q;
  cevc_pkg::cevc_vec_t active_d;
  cevc_pkg::cevc_vec_t cand;
  cevc_pkg::cevc_vec_t en_mask;
  cevc_pkg::cevc_vec_t elig;
  cevc_pkg::cevc_vec_t take_oh;
  cevc_pkg::cevc_vec_t ret_oh;
  logic [4:0] pick_r;
  logic [4:0] top_r;
  cevc_pkg::cevc_lvl_t pick;
  logic take;
  logic ret_ok;

  assign cand = latch_q | edge_evt;
  // levels 5..15 obey unmask bits and global enable
  assign en_mask = cevc_pkg::UNMASKABLE |
    (cevc_pkg::MASKABLE & EVENT_UNMASK & {16{GLOBAL_EN}});
  assign elig = cand & en_mask;
  assign pick_r = cevc_first(elig);
  assign top_r = cevc_first(active_q);
  assign pick = pick_r[3:0];
  // strictly above every active event, else wait
  assign take = pick_r[4] & (~top_r[4] | (pick < top_r[3:0]));
  assign take_oh = take ? (16'h0001 << pick) : 16'h0000;
  assign ret_ok = RET_REQ & active_q[RET_LEVEL];
  assign ret_oh = ret_ok ? (16'h0001 << RET_LEVEL) : 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // latch bits
  always_comb begin
    // a new edge during activation stays queued
    latch_d = (latch_q & ~take_oh) | (edge_evt & ~(take_oh & ~latch_q));
    latch_d[cevc_pkg::LVL_GEN] = 1'b0;
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      latch_q <= cevc_pkg::LATCH_RST;
    end else begin
      latch_q <= latch_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // active bits
  always_comb begin
    if (take && pick == cevc_pkg::LVL_RST) begin
      active_d = take_oh;
    end else begin
      active_d = (active_q & ~ret_oh) | take_oh;
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      active_q <= cevc_pkg::ACTIVE_RST;
    end else begin
      active_q <= active_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // dispatch outputs
  logic take_q;
  cevc_pkg::cevc_lvl_t take_lvl_q;
  logic emu_q;
  logic core_rst_q;
  logic ret_valid_q;

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      take_q <= 1'b0;
      take_lvl_q <= cevc_pkg::LVL_EMU;
    end else begin
      take_q <= take;
      if (take) begin
        take_lvl_q <= pick;
      end
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      emu_q <= 1'b0;
    end else if (take && pick == cevc_pkg::LVL_EMU) begin
      emu_q <= 1'b1;
    end else if (ret_ok && RET_LEVEL == cevc_pkg::LVL_EMU) begin
      emu_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      core_rst_q <= 1'b0;
    end else begin
      core_rst_q <= take && pick == cevc_pkg::LVL_RST;
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ret_valid_q <= 1'b0;
    end else begin
      ret_valid_q <= ret_ok;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // return address store
  cevc_mem_if mem_bus ();

  assign mem_bus.wr_en = take;
  assign mem_bus.wr_idx = pick;
  assign mem_bus.wr_data = CORE_PC;
  assign mem_bus.rd_en = ret_ok;
  assign mem_bus.rd_idx = RET_LEVEL;

  cevc_retmem u_retmem (
    .CLK(CLK),
    .SYS_RST(SYS_RST),
    .bus(mem_bus)
  );

  assign TAKE_PULSE = take_q;
  assign TAKE_LEVEL = take_lvl_q;
  assign EVENT_ACTIVE = active_q;
  assign EVENT_LATCH = latch_q;
  assign EMU_MODE = emu_q;
  assign CORE_RESET = core_rst_q;
  // hold commit while an exception waits
  assign COMMIT_BLOCK = EXC_REQ | latch_q[cevc_pkg::LVL_EXC];
  assign RET_VALID = ret_valid_q;
  assign RET_ADDR = mem_bus.rd_data;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  sequence gp7_edge_s;
    s2_q[cevc_pkg::PIN_GP0] && !s3_q[cevc_pkg::PIN_GP0];
  endsequence

  sequence gp7_taken_s;
    gp7_edge_s ##0 (take && pick == cevc_pkg::LVL_GP_FIRST);
  endsequence

  AST_LATCH_SET: assert property (
    (edge_evt & ~take_oh & ~16'h0010) != 16'h0000 |=>
      (latch_q & $past(edge_evt & ~take_oh & ~16'h0010)) ==
      $past(edge_evt & ~take_oh & ~16'h0010))
    else $error("edge did not set latch");

  AST_LATCH_CLR: assert property (
    take && latch_q[pick] && !edge_evt[pick] |=> !latch_q[$past(pick)])
    else $error("latch not cleared on activation");

  AST_NEST: assert property (
    take && top_r[4] && pick != cevc_pkg::LVL_RST &&
      !(ret_ok && RET_LEVEL == top_r[3:0]) |->
      pick < top_r[3:0] ##1 active_q[$past(top_r[3:0])])
    else $error("preemption broke nesting");

  AST_PRIO: assert property (
    take |-> (elig & ((16'h0001 << pick) - 16'h0001)) == 16'h0000)
    else $error("lower ranked event dispatched first");

  AST_NMI: assert property (
    cand[cevc_pkg::LVL_NMI] && active_q[2:0] == 3'h0 && cand[1:0] == 2'h0
      |=> active_q[cevc_pkg::LVL_NMI])
    else $error("nmi not taken");

  AST_MIN_LAT: assert property (
    gp7_taken_s |=> active_q[cevc_pkg::LVL_GP_FIRST] && take_q)
    else $error("general level not active after edge");

  AST_EMU: assert property (
    take && pick == cevc_pkg::LVL_EMU |=> EMU_MODE && TAKE_LEVEL == 4'h0)
    else $error("emulation mode not entered");

  AST_RESET: assert property (
    take && pick == cevc_pkg::LVL_RST |=> CORE_RESET ##1 !CORE_RESET)
    else $error("reset pulse wrong");

  AST_EXC: assert property (
    EXC_REQ |-> COMMIT_BLOCK ##1
      (active_q[cevc_pkg::LVL_EXC] || latch_q[cevc_pkg::LVL_EXC]))
    else $error("exception neither taken nor held");

  AST_RET: assert property (
    ret_ok && !(take && pick == RET_LEVEL) |=>
      RET_VALID && !active_q[$past(RET_LEVEL)])
    else $error("return not served");

  AST_MASK: assert property (
    take |-> en_mask[pick] && pick != cevc_pkg::LVL_GEN)
    else $error("masked event dispatched");
endmodule
`default_nettype wire

// ### rtl/cevc_pkg.sv
// Purpose: shared constants for the core event controller
// Assumes: sixteen event classes, level 0 is the highest priority
// Notes: none
`default_nettype none
package cevc_pkg;
  localparam int NUM_EVT = 16;
  localparam int LVL_W = 4;
  localparam int ADDR_W = 32;
  localparam int PIN_W = 15;
  localparam logic [3:0] LVL_EMU = 4'h0;
  localparam logic [3:0] LVL_RST = 4'h1;
  localparam logic [3:0] LVL_NMI = 4'h2;
  localparam logic [3:0] LVL_EXC = 4'h3;
  localparam logic [3:0] LVL_GEN = 4'h4;
  localparam logic [3:0] LVL_HWE = 4'h5;
  localparam logic [3:0] LVL_TMR = 4'h6;
  localparam logic [3:0] LVL_GP_FIRST = 4'h7;
  localparam logic [3:0] LVL_GP_LAST = 4'hf;
  localparam int NUM_GP = 9;
  // pin vector positions
  localparam int PIN_EMU = 0;
  localparam int PIN_RST = 1;
  localparam int PIN_NMI = 2;
  localparam int PIN_WDOG = 3;
  localparam int PIN_HWE = 4;
  localparam int PIN_TMR = 5;
  localparam int PIN_GP0 = 6;
  // reset values
  localparam logic [15:0] ACTIVE_RST = 16'h0000;
  localparam logic [15:0] LATCH_RST = 16'h0000;
  localparam logic [31:0] ADDR_RST = 32'h0000_0000;
  // levels that no mask can block
  localparam logic [15:0] UNMASKABLE = 16'h000f;
  localparam logic [15:0] MASKABLE = 16'hffe0;
  // timing in core clock cycles
  localparam int EDGE_DETECT_CYC = 2;
  localparam int MIN_LATENCY_CYC = 3;
  typedef logic [LVL_W-1:0] cevc_lvl_t;
  typedef logic [NUM_EVT-1:0] cevc_vec_t;
endpackage
`default_nettype wire

// ### rtl/cevc_mem_if.sv
// Purpose: link between event controller and its return address store
// Assumes: one write and one read port, same clock
// Notes: read data are registered inside the store
`timescale 1ns/100ps
`default_nettype none
interface cevc_mem_if;
  logic wr_en;
  cevc_pkg::cevc_lvl_t wr_idx;
  logic [cevc_pkg::ADDR_W-1:0] wr_data;
  logic rd_en;
  cevc_pkg::cevc_lvl_t rd_idx;
  logic [cevc_pkg::ADDR_W-1:0] rd_data;
  modport ctl(output wr_en, output wr_idx, output wr_data, output rd_en,
    output rd_idx, input rd_data);
  modport mem(input wr_en, input wr_idx, input wr_data, input rd_en,
    input rd_idx, output rd_data);
endinterface
`default_nettype wire

// ### rtl/cevc_retmem.sv
// Purpose: one return address word per event class
// Assumes: write and read in the same cycle use old contents
// Notes: array itself is not reset
`timescale 1ns/100ps
`default_nettype none
module cevc_retmem (
  input wire logic CLK,
  input wire logic SYS_RST,
  cevc_mem_if.mem bus
);
  logic [cevc_pkg::ADDR_W-1:0] mem_q [cevc_pkg::NUM_EVT];
  logic [cevc_pkg::ADDR_W-1:0] rd_q;

  always_ff @(posedge CLK) begin
    if (bus.wr_en) begin
      mem_q[bus.wr_idx] <= bus.wr_data;
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rd_q <= cevc_pkg::ADDR_RST;
    end else if (bus.rd_en) begin
      rd_q <= mem_q[bus.rd_idx];
    end
  end

  assign bus.rd_data = rd_q;
endmodule
`default_nettype wire

// ### dv/cevc_src_model.sv
// Purpose: event source model driving the event pins
// Assumes: one fire cycle becomes a two cycle pin pulse
// Notes: pins change on the falling edge only
`timescale 1ns/100ps
`default_nettype none
module cevc_src_model (
  input wire logic clk,
  input wire logic [14:0] fire,
  output logic [14:0] pins
);
  logic [14:0] req_q;
  logic [14:0] hold_q;
  initial begin
    req_q = 15'h0000;
    hold_q = 15'h0000;
    pins = 15'h0000;
  end
  always @(posedge clk) begin
    req_q <= fire;
  end
  // pulse two cycles wide, then back low
  always @(negedge clk) begin
    pins <= req_q | hold_q;
    hold_q <= req_q;
  end
endmodule
`default_nettype wire

// ### dv/cevc_top_test.sv
// Purpose: self-checking bench for the core event controller
// Assumes: pins fired only while no other take is due
// Notes: model tracks active and latched levels
`timescale 1ns/100ps
`default_nettype none
module cevc_top_test;
  logic CLK, SYS_RST, EXC_REQ, GLOBAL_EN, RET_REQ, TAKE_PULSE, EMU_MODE;
  logic CORE_RESET, COMMIT_BLOCK, RET_VALID, ret_pend, rv_exp;
  logic [3:0] RET_LEVEL, TAKE_LEVEL;
  logic [14:0] fire, pins;
  logic [15:0] EVENT_UNMASK, EVENT_ACTIVE, EVENT_LATCH, act_m, pend_m;
  logic [31:0] CORE_PC, RET_ADDR, seed, v;
  logic [31:0] pc_m [16];
  int fail_count, tests_run, e, lat, rst_m, rst_seen, ret_l;
  cevc_src_model u_src (.clk(CLK), .fire(fire), .pins(pins));
  cevc_top u_dut (.CLK(CLK), .SYS_RST(SYS_RST), .EMU_REQ(pins[0]),
    .RESET_REQ(pins[1]), .NMI_PIN(pins[2]), .WDOG_NMI(pins[3]),
    .HWERR_REQ(pins[4]), .TIMER_REQ(pins[5]), .GEN_IRQ(pins[14:6]),
    .EXC_REQ(EXC_REQ), .GLOBAL_EN(GLOBAL_EN), .EVENT_UNMASK(EVENT_UNMASK),
    .CORE_PC(CORE_PC), .RET_REQ(RET_REQ), .RET_LEVEL(RET_LEVEL),
    .TAKE_PULSE(TAKE_PULSE), .TAKE_LEVEL(TAKE_LEVEL),
    .EVENT_ACTIVE(EVENT_ACTIVE), .EVENT_LATCH(EVENT_LATCH),
    .EMU_MODE(EMU_MODE), .CORE_RESET(CORE_RESET),
    .COMMIT_BLOCK(COMMIT_BLOCK), .RET_VALID(RET_VALID), .RET_ADDR(RET_ADDR));
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    if (fail_count == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // lowest eligible level above every active one
  function automatic int pick();
    logic [15:0] el;
    el = pend_m & ((EVENT_UNMASK & {16{GLOBAL_EN}}) | 16'h000f) & 16'hffef;
    for (int i = 0; i < 16; i++) begin
      if (act_m[i]) return -1;
      if (el[i]) return i;
    end
    return -1;
  endfunction
  task automatic idle(input int n);
    repeat (n) @(negedge CLK);
  endtask
  task automatic fire_pins(input logic [14:0] f);
    for (int k = 0; k < 15; k++) begin
      if (f[k]) pend_m[k < 3 ? k : (k == 3 ? 2 : k + 1)] = 1'b1;
    end
    fire = f;
    @(negedge CLK);
    fire = 15'h0000;
  endtask
  task automatic ret(input int l);
    RET_REQ = 1'b1;
    RET_LEVEL = l[3:0];
    ret_l = l;
    ret_pend = act_m[l];
    @(negedge CLK);
    RET_REQ = 1'b0;
    idle(5);
  endtask
  task automatic exc_pulse();
    EXC_REQ = 1'b1;
    pend_m[3] = 1'b1;
    #1 check("commit block", COMMIT_BLOCK, 1);
    @(negedge CLK);
    EXC_REQ = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end
  always begin
    @(negedge CLK);
    #2;
    if (!SYS_RST) begin
      if (TAKE_PULSE === 1'b1) begin
        e = pick();
        check("take level", TAKE_LEVEL, e);
        if (e >= 0) begin
          act_m[e] = 1'b1;
          pend_m[e] = 1'b0;
          pc_m[e] = CORE_PC;
          if (e == 1) act_m = 16'h0002;
          if (e == 1) rst_m++;
        end
      end
      check("ret valid", RET_VALID, rv_exp);
      if (rv_exp) check("ret addr", RET_ADDR, pc_m[ret_l]);
      if (rv_exp) act_m[ret_l] = 1'b0;
      rv_exp = ret_pend;
      ret_pend = 1'b0;
      if (CORE_RESET === 1'b1) rst_seen++;
      check("active", EVENT_ACTIVE, act_m);
      check("emu mode", EMU_MODE, act_m[0]);
    end
  end
  initial begin
    #(25 * 20000);
    fail_count++;
    complete_run();
  end
  initial begin
    {SYS_RST, GLOBAL_EN} = 2'h3;
    {EXC_REQ, RET_REQ, ret_pend, rv_exp} = 4'h0;
    {RET_LEVEL, fire, act_m, pend_m} = '0;
    EVENT_UNMASK = 16'hffff;
    CORE_PC = 32'h0000_0000;
    seed = 32'h0001_3cfb;
    {fail_count, tests_run, rst_m, rst_seen, ret_l} = '0;
    idle(10);
    SYS_RST = 1'b0;
    idle(4);
    check("latch", EVENT_LATCH, 16'h0000);
    CORE_PC = rnd();
    fire_pins(15'h0040);
    lat = 1;
    while (TAKE_PULSE !== 1'b1 && lat < 20) begin
      @(negedge CLK);
      lat++;
    end
    check("latency", lat >= 4 && lat <= 5, 1);
    idle(3);
    ret(7);
    for (int r = 0; r < 4; r++) begin
      EVENT_UNMASK = 16'h0000;
      CORE_PC = rnd();
      v = rnd() & 32'h7ff0;
      fire_pins(v[14:0]);
      idle(6);
      check("latch", EVENT_LATCH, pend_m);
      EVENT_UNMASK = rnd();
      idle(6);
      EVENT_UNMASK = 16'hffff;
      for (int n = 0; n < 14; n++) begin
        for (int i = 15; i >= 0; i--) if (act_m[i]) e = i;
        if (act_m != 16'h0000) ret(e);
      end
    end
    fire_pins(15'h4000);
    idle(6);
    fire_pins(15'h4000);
    idle(6);
    check("latch", EVENT_LATCH, pend_m);
    CORE_PC = rnd();
    fire_pins(15'h0020);
    idle(6);
    ret(6);
    ret(15);
    ret(15);
    GLOBAL_EN = 1'b0;
    EVENT_UNMASK = 16'h0000;
    fire_pins(15'h0010);
    idle(6);
    fire_pins(15'h0004);
    idle(6);
    ret(2);
    fire_pins(15'h0008);
    idle(6);
    exc_pulse();
    idle(4);
    check("commit block", COMMIT_BLOCK, 1);
    ret(2);
    ret(3);
    GLOBAL_EN = 1'b1;
    EVENT_UNMASK = 16'hffff;
    idle(6);
    ret(5);
    fire_pins(15'h0001);
    idle(6);
    ret(0);
    ret(9);
    fire_pins(15'h0040);
    idle(6);
    fire_pins(15'h0002);
    idle(6);
    ret(1);
    check("core reset", rst_seen, rst_m);
    complete_run();
  end
endmodule
`default_nettype wire
